/* logic/hbls_consts.svh */
// constants for the host bus byte-lane steering block
`ifndef HBLS_CONSTS_SVH
`define HBLS_CONSTS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define HBLS_ADDR_W       8
`define HBLS_DATA_W       16

// ****************************************************************
// register map selection
// ****************************************************************
// low-strap map is the high-strap map with these address bits flipped
`define HBLS_BIG_MAP_XOR  8'h03

// ****************************************************************
// reset values
// ****************************************************************
`define HBLS_STRAP_RST    1'b1
`define HBLS_ADDR_RST     8'h00
`define HBLS_DATA_RST     16'h0000

// ****************************************************************
// timing counts
// ****************************************************************
// clock edges from the taking edge to the first edge that samples the answer high
`define HBLS_ACK_LAT      3

`endif

/* logic/hbls_pkg.sv */
// types and lane decode functions for the byte-lane steering block
`include "hbls_consts.svh"

package hbls_pkg;

   // ****************************************************************
   // transfer kinds and controller states
   // ****************************************************************
   typedef enum logic [1:0] {
      XFER_BYTE   = 2'h0,  // lone byte, lane from address bit 0
      XFER_WORD   = 2'h1,  // plain 16-bit word, never reordered
      XFER_STREAM = 2'h2   // two successive stream bytes
   } hbls_xfer_type;

   // gray codes along idle -> issue -> core -> answer
   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_ISSUE  = 2'h1,
      ST_CORE   = 2'h3,
      ST_ANSWER = 2'h2
   } hbls_state_type;

   // ****************************************************************
   // shared decode
   // ****************************************************************
   // true when a lone byte sits on the upper lane
   function automatic logic hbls_hi_lane(input logic strap, input logic a0);
      hbls_hi_lane = strap ? a0 : ~a0;
   endfunction

   // exchange the two lanes of a word
   function automatic logic [15:0] hbls_swap(input logic [15:0] w);
      hbls_swap = {w[7:0], w[15:8]};
   endfunction

endpackage

/* logic/hbls_lane_if.sv */
// carrier between the steering controller and its lane mapper
`timescale 1ns/1ps
`include "hbls_consts.svh"

interface hbls_lane_if;
   logic                       strap;      // strap level held for this transfer
   hbls_pkg::hbls_xfer_type    kind;       // transfer kind
   logic [`HBLS_ADDR_W-1:0]    host_addr;  // address as the host gave it
   logic [`HBLS_DATA_W-1:0]    host_wdata; // host bus word as written
   logic [`HBLS_DATA_W-1:0]    core_rdata; // core word, stream first byte low
   logic [`HBLS_ADDR_W-1:0]    core_addr;  // address in the internal map
   logic [`HBLS_DATA_W-1:0]    core_wdata; // write word, stream first byte low
   logic [`HBLS_DATA_W-1:0]    bus_rdata;  // read word placed on host lanes

   modport ctrl (output strap, kind, host_addr, host_wdata, core_rdata,
                 input core_addr, core_wdata, bus_rdata);
   modport mapper (input strap, kind, host_addr, host_wdata, core_rdata,
                   output core_addr, core_wdata, bus_rdata);
endinterface

/* logic/hbls_lane_map.sv */
// lane placement, byte ordering and register map selection
`timescale 1ns/1ps
`include "hbls_consts.svh"

module hbls_lane_map (
   // carrier from the controller
   hbls_lane_if.mapper lane
);

   // ****************************************************************
   // lane decode
   // ****************************************************************
   logic hi_lane;  // lone byte on the upper lane
   assign hi_lane = hbls_pkg::hbls_hi_lane(lane.strap, lane.host_addr[0]);

   // map choice follows the strap level latched for the transfer
   assign lane.core_addr = lane.strap ? lane.host_addr
                                      : (lane.host_addr ^ `HBLS_BIG_MAP_XOR);

   // host write word into canonical order
   always_comb begin
      case (lane.kind)
         hbls_pkg::XFER_BYTE: begin
            // lone byte taken from the lane the address selects
            lane.core_wdata = {8'h00, hi_lane ? lane.host_wdata[15:8]
                                              : lane.host_wdata[7:0]};
         end
         hbls_pkg::XFER_STREAM: begin
            // high strap: low lane first; low strap: high lane first
            lane.core_wdata = lane.strap ? lane.host_wdata
                                         : hbls_pkg::hbls_swap(lane.host_wdata);
         end
         default: begin
            // plain words keep their layout whatever the strap
            lane.core_wdata = lane.host_wdata;
         end
      endcase
   end

   // canonical core word onto host lanes
   always_comb begin
      case (lane.kind)
         hbls_pkg::XFER_BYTE: begin
            // unused lane reads zero so a wrong-lane read is obvious
            lane.bus_rdata = hi_lane ? {lane.core_rdata[7:0], 8'h00}
                                     : {8'h00, lane.core_rdata[7:0]};
         end
         hbls_pkg::XFER_STREAM: begin
            lane.bus_rdata = lane.strap ? lane.core_rdata
                                        : hbls_pkg::hbls_swap(lane.core_rdata);
         end
         default: begin
            lane.bus_rdata = lane.core_rdata;
         end
      endcase
   end

endmodule

/* logic/hbls_lane_steer.sv */
// host bus byte-lane steering controller, top of the block
`timescale 1ns/1ps
`include "hbls_consts.svh"

module hbls_lane_steer (
   // clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       rstn,
   // lane-order strap pin
   input  wire logic                       lane_order_pin,
   // host request
   input  wire logic                       req_valid,
   input  wire logic                       req_write,
   input  wire hbls_pkg::hbls_xfer_type    req_kind,
   input  wire logic [`HBLS_ADDR_W-1:0]    req_addr,
   input  wire logic [`HBLS_DATA_W-1:0]    ad_in,
   // host answer, data pins split into out and enable
   output logic [`HBLS_DATA_W-1:0]         ad_out,
   output logic                            ad_oe,
   output logic                            host_ack,
   output logic                            host_ready,
   // internal core side
   output logic                            core_wr,
   output logic                            core_rd,
   output hbls_pkg::hbls_xfer_type         core_kind,
   output logic [`HBLS_ADDR_W-1:0]         core_addr,
   output logic [`HBLS_DATA_W-1:0]         core_wdata,
   input  wire logic [`HBLS_DATA_W-1:0]    core_rdata
);

   // ****************************************************************
   // strap synchroniser
   // ****************************************************************
   logic strap_s1_q;  // first stage, read only by the second
   logic strap_s2_q;  // second stage
   logic strap_s3_q;  // third stage
   logic strap_q;     // filtered strap level

   // three stages; a new level counts once stages two and three agree
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         strap_s1_q <= `HBLS_STRAP_RST;
         strap_s2_q <= `HBLS_STRAP_RST;
         strap_s3_q <= `HBLS_STRAP_RST;
         strap_q    <= `HBLS_STRAP_RST;
      end else begin
         strap_s1_q <= lane_order_pin;
         strap_s2_q <= strap_s1_q;
         strap_s3_q <= strap_s2_q;
         if (strap_s2_q == strap_s3_q) begin
            strap_q <= strap_s3_q;
         end
      end
   end

   // ****************************************************************
   // transfer sequencing
   // ****************************************************************
   hbls_pkg::hbls_state_type  state_q;    // controller state
   hbls_pkg::hbls_state_type  state_d;    // next state
   logic                      take;       // request taken this cycle

   assign take = req_valid && (state_q == hbls_pkg::ST_IDLE);

   // fixed walk, no branch looks at the strap
   always_comb begin
      case (state_q)
         hbls_pkg::ST_IDLE:   state_d = take ? hbls_pkg::ST_ISSUE : hbls_pkg::ST_IDLE;
         hbls_pkg::ST_ISSUE:  state_d = hbls_pkg::ST_CORE;
         hbls_pkg::ST_CORE:   state_d = hbls_pkg::ST_ANSWER;
         hbls_pkg::ST_ANSWER: state_d = hbls_pkg::ST_IDLE;
         default:             state_d = hbls_pkg::ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= hbls_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************************************
   // request capture
   // ****************************************************************
   logic                      xfer_strap_q;  // strap frozen per transfer
   logic                      write_q;       // captured direction
   hbls_pkg::hbls_xfer_type   kind_q;        // captured kind
   logic [`HBLS_ADDR_W-1:0]   addr_q;        // captured host address
   logic [`HBLS_DATA_W-1:0]   wdata_q;       // captured host write word

   // freezing the strap keeps both bytes of one transfer in one order
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         xfer_strap_q <= `HBLS_STRAP_RST;
         write_q      <= 1'b0;
         kind_q       <= hbls_pkg::XFER_BYTE;
         addr_q       <= `HBLS_ADDR_RST;
         wdata_q      <= `HBLS_DATA_RST;
      end else if (take) begin
         xfer_strap_q <= strap_q;
         write_q      <= req_write;
         kind_q       <= req_kind;
         addr_q       <= req_addr;
         wdata_q      <= ad_in;
      end
   end

   // ****************************************************************
   // lane mapper
   // ****************************************************************
   hbls_lane_if lane ();

   assign lane.strap      = xfer_strap_q;
   assign lane.kind       = kind_q;
   assign lane.host_addr  = addr_q;
   assign lane.host_wdata = wdata_q;
   assign lane.core_rdata = core_rdata;

   hbls_lane_map u_map (
      .lane (lane.mapper)
   );

   // ****************************************************************
   // core side strobes
   // ****************************************************************
   // one-cycle strobe while in the core state
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         core_wr    <= 1'b0;
         core_rd    <= 1'b0;
         core_kind  <= hbls_pkg::XFER_BYTE;
         core_addr  <= `HBLS_ADDR_RST;
         core_wdata <= `HBLS_DATA_RST;
      end else begin
         core_wr <= (state_q == hbls_pkg::ST_ISSUE) && write_q;
         core_rd <= (state_q == hbls_pkg::ST_ISSUE) && !write_q;
         if (state_q == hbls_pkg::ST_ISSUE) begin
            core_kind  <= kind_q;
            core_addr  <= lane.core_addr;
            core_wdata <= lane.core_wdata;
         end
      end
   end

   // ****************************************************************
   // host answer
   // ****************************************************************
   // ack and drive timing tie to the state walk only
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ad_out     <= `HBLS_DATA_RST;
         ad_oe      <= 1'b0;
         host_ack   <= 1'b0;
         host_ready <= 1'b0;
      end else begin
         host_ack   <= (state_q == hbls_pkg::ST_CORE);
         ad_oe      <= (state_q == hbls_pkg::ST_CORE) && !write_q;
         host_ready <= (state_d == hbls_pkg::ST_IDLE);
         if ((state_q == hbls_pkg::ST_CORE) && !write_q) begin
            ad_out <= lane.bus_rdata;
         end
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   a_ack_fixed_lat: assert property (
      @(posedge core_clk) disable iff (!rstn)
      take |-> !host_ack [*3] ##1 host_ack)
      else $error("answer not on the fixed cycle");

   a_ack_pulse_oe: assert property (
      @(posedge core_clk) disable iff (!rstn)
      host_ack |-> (ad_oe == !write_q) ##1 (!host_ack && !ad_oe))
      else $error("answer or drive held too long");

   a_map_select: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (core_wr || core_rd) |->
         core_addr == (xfer_strap_q ? addr_q : (addr_q ^ `HBLS_BIG_MAP_XOR)))
      else $error("wrong register map");

   a_word_straight: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (core_wr && core_kind == hbls_pkg::XFER_WORD) |-> core_wdata == wdata_q)
      else $error("plain word reordered");

   a_stream_lo_first: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (core_wr && core_kind == hbls_pkg::XFER_STREAM && xfer_strap_q) |->
         core_wdata[7:0] == wdata_q[7:0] && core_wdata[15:8] == wdata_q[15:8])
      else $error("stream order wrong, strap high");

   a_stream_hi_first: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (core_wr && core_kind == hbls_pkg::XFER_STREAM && !xfer_strap_q) |->
         core_wdata[7:0] == wdata_q[15:8] && core_wdata[15:8] == wdata_q[7:0])
      else $error("stream order wrong, strap low");

   a_byte_lane_high: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (host_ack && !write_q && kind_q == hbls_pkg::XFER_BYTE && xfer_strap_q) |->
         ad_out == (addr_q[0] ? {$past(core_rdata[7:0]), 8'h00}
                              : {8'h00, $past(core_rdata[7:0])}))
      else $error("byte lane wrong, strap high");

   a_byte_lane_low: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (core_wr && core_kind == hbls_pkg::XFER_BYTE && !xfer_strap_q) |->
         core_wdata[7:0] == (addr_q[0] ? wdata_q[7:0] : wdata_q[15:8]))
      else $error("byte lane wrong, strap low");

endmodule

/* dv/hbls_host_model.sv */
// host processor bus model that drives requests into the steering block
`timescale 1ns/1ps
`include "hbls_consts.svh"

module hbls_host_model (
   // clock
   input  wire logic                       core_clk,
   // strap and request towards the block
   output logic                            lane_order_pin,
   output logic                            req_valid,
   output logic                            req_write,
   output hbls_pkg::hbls_xfer_type         req_kind,
   output logic [`HBLS_ADDR_W-1:0]         req_addr,
   output logic [`HBLS_DATA_W-1:0]         ad_in,
   // answer from the block
   input  wire logic [`HBLS_DATA_W-1:0]    ad_out,
   input  wire logic                       ad_oe,
   input  wire logic                       host_ack,
   input  wire logic                       host_ready
);
   // ****************************************************************
   // idle levels
   // ****************************************************************
   // lines start quiet; strap comes up little-endian style
   initial begin
      lane_order_pin = 1'b1;
      req_valid      = 1'b0;
      req_write      = 1'b0;
      req_kind       = hbls_pkg::XFER_WORD;
      req_addr       = 8'h00;
      ad_in          = 16'h0000;
   end

   // strap only moves while reset is held, never in mid-run
   task automatic set_strap(input logic s);
      lane_order_pin <= s;
   endtask

   // ****************************************************************
   // one bus transfer
   // ****************************************************************
   // request held until taken, then kept up hold more edges while busy;
   // released write, address and data lines show the inverse so stale values never look valid
   task automatic xfer(input logic wr, input logic [1:0] k, input logic [7:0] a,
                       input logic [15:0] d, input int hold,
                       output logic [15:0] rd, output logic oe, output int lat);
      int n;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_kind  <= hbls_pkg::hbls_xfer_type'(k);
      req_addr  <= a;   // lone byte sits on the lane bit0 picks
      ad_in     <= d;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (host_ready !== 1'b1 && n < 50);
      // this edge took the request; count edges until the answer
      for (lat = 0; lat < 10 && !(lat > 0 && host_ack === 1'b1); lat++) begin
         if (lat == hold) begin
            req_valid <= 1'b0;
            req_write <= ~wr;
            req_addr  <= ~a;
            ad_in     <= ~d;
         end
         @(posedge core_clk);
      end
      rd = ad_out;
      oe = ad_oe;
   endtask
endmodule

/* dv/tb_top.sv */
// self-checking bench for the host bus byte-lane steering block
`timescale 1ns/1ps
`include "hbls_consts.svh"

module tb_top;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic                       core_clk;     // 250 MHz system clock
   logic                       rstn;         // async reset, active low
   logic                       lane_order_pin;
   logic                       req_valid;
   logic                       req_write;
   hbls_pkg::hbls_xfer_type    req_kind;
   logic [`HBLS_ADDR_W-1:0]    req_addr;
   logic [`HBLS_DATA_W-1:0]    ad_in;
   logic [`HBLS_DATA_W-1:0]    ad_out;
   logic                       ad_oe;
   logic                       host_ack;
   logic                       host_ready;
   logic                       core_wr;
   logic                       core_rd;
   hbls_pkg::hbls_xfer_type    core_kind;
   logic [`HBLS_ADDR_W-1:0]    core_addr;
   logic [`HBLS_DATA_W-1:0]    core_wdata;
   logic [`HBLS_DATA_W-1:0]    core_rdata;
   logic [15:0]                mem [256];    // core register contents
   int                         err_count;    // mismatches
   int                         n_tests;      // comparisons
   int                         cycles;       // timeout counter
   int                         strobes;      // core strobes seen
   integer                     seed = 32'h79d16632;

   // ****************************************************************
   // clock, core model, watchdog
   // ****************************************************************
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // core answers only while read strobe is up, garbage otherwise
   assign core_rdata = core_rd ? mem[core_addr] : ~mem[core_addr];

   // strobes counted to catch doubly taken requests
   always @(posedge core_clk) begin
      cycles++;
      strobes += int'(core_wr) + int'(core_rd);
      if (cycles == 20000) begin
         err_count++;
         summarize();
      end
   end

   hbls_host_model host (.core_clk(core_clk), .lane_order_pin(lane_order_pin),
      .req_valid(req_valid), .req_write(req_write), .req_kind(req_kind),
      .req_addr(req_addr), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
      .host_ack(host_ack), .host_ready(host_ready));

   hbls_lane_steer dut (.core_clk(core_clk), .rstn(rstn), .lane_order_pin(lane_order_pin),
      .req_valid(req_valid), .req_write(req_write), .req_kind(req_kind),
      .req_addr(req_addr), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
      .host_ack(host_ack), .host_ready(host_ready), .core_wr(core_wr),
      .core_rd(core_rd), .core_kind(core_kind), .core_addr(core_addr),
      .core_wdata(core_wdata), .core_rdata(core_rdata));

   // ****************************************************************
   // compare and report
   // ****************************************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("errors=%0d checks=%0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // one strap setting: reset, then mixed traffic
   // ****************************************************************
   task automatic run_strap(input logic s);
      logic [15:0] rd, d, r, exp;
      logic [7:0]  a, ia;
      logic [1:0]  k;
      logic        oe, wr, hi;
      int          lat, n0;
      host.set_strap(s);
      rstn <= 1'b0;
      repeat (16) @(posedge core_clk);
      check(16'({host_ack, ad_oe, host_ready, core_wr, core_rd}), 16'h0000);
      rstn <= 1'b1;
      repeat (6) @(posedge core_clk);
      for (int i = 0; i < 150; i++) begin
         // first eight cover every kind code in both directions
         k  = (i < 8) ? 2'(i) : 2'($random(seed));
         wr = (i < 8) ? i[2] : 1'($random(seed));
         a  = 8'($random(seed));
         d  = 16'($random(seed));
         n0 = strobes;
         host.xfer(wr, k, a, d, i % 3, rd, oe, lat);
         hi = s ? a[0] : ~a[0];
         ia = s ? a : a ^ `HBLS_BIG_MAP_XOR;
         r  = mem[ia];
         check(16'(lat), 16'(`HBLS_ACK_LAT));
         check(16'(strobes - n0), 16'h0001);
         check(16'(oe), 16'(!wr));
         check(16'(core_addr), 16'(ia));
         if (k != 2'h3) check(16'(core_kind), 16'(k));
         // expected lane layout per kind
         case (k)
            2'h0: begin
               if (wr) exp = {8'h00, hi ? d[15:8] : d[7:0]};
               else exp = hi ? {r[7:0], 8'h00} : {8'h00, r[7:0]};
            end
            2'h2: begin
               exp = s ? (wr ? d : r) : (wr ? {d[7:0], d[15:8]} : {r[7:0], r[15:8]});
            end
            default: begin
               exp = wr ? d : r;
            end
         endcase
         if (wr) check(core_wdata, exp);
         else check(rd, exp);
      end
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      rstn = 1'b0;
      err_count = 0;
      n_tests = 0;
      cycles = 0;
      strobes = 0;
      for (int i = 0; i < 256; i++) mem[i] = 16'($random(seed));
      run_strap(1'b1);
      run_strap(1'b0);
      summarize();
   end
endmodule
